// ### src/interrupt_control_logic.v
// interrupt control logic: priority controller, vector shadow, diag ports
`timescale 1ns/1ps
`default_nettype none
`include "intctl_defs.vh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module interrupt_control_logic
(
   input  wire              clk_i,
   input  wire              arst_n_i,
   input  wire              clk_en_i,
   input  wire              reset_i,
   input  wire [`ADDR_W-1:0] io_addr_lines_i,
   input  wire              io_read_strobe_n_i,
   input  wire              io_write_strobe_n_i,
   input  wire              dma_addr_inhibit_i,
   input  wire [7:0]        data_i,
   output reg  [7:0]        data_o,
   output reg               data_oe_o,
   output reg               buffer_dir_n_o,
   input  wire [7:2]        ext_request_lines_i,
   input  wire              timer_irq_i,
   input  wire              kbd_irq_i,
   input  wire              mouse_irq_i,
   input  wire              rtc_irq_i,
   input  wire              ack_pulse_n_i,
   output reg               cpu_irq_out_o,
   output reg               nmi_force_o
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // {found, level}; level 0 has the highest priority
   function [3:0] prio;
      input [7:0] v;
      integer k;
      begin
         prio = 4'h0;
         for (k = 7; k >= 0; k = k - 1)
            if (v[k])
               prio = {1'b1, k[2:0]};
      end
   endfunction

   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg  [7:0] pending_requests;
   reg  [7:0] in_service_levels;
   reg  [7:0] level_mask;
   reg  [7:0] vector_base_word;
   reg  [7:0] vector_shadow;
   reg  [7:0] diag_ctrl;
   reg  [7:2] force_lines;
   reg        force_nmi;
   reg        level_trig;
   reg        need_w3;
   reg        need_w4;
   reg        auto_eoi;
   reg  [1:0] op_word_three;
   reg  [1:0] init_state;
   reg  [1:0] ack_state;
   reg  [2:0] ack_level;
   reg  [7:0] ack_vector;
   reg  [7:0] req_prev;
   reg        wr_prev;
   reg        ack_prev;

   wire [`SYNC_W-1:0] sync_lines;
   wire [7:0]         req_lines;
   wire               shared_src;

   assign shared_src = kbd_irq_i | mouse_irq_i | rtc_irq_i;

   req_sync u_req_sync
   (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .clk_en_i (clk_en_i),
      .async_i  ({ext_request_lines_i, shared_src, timer_irq_i}),
      .sync_o   (sync_lines)
   );

   // forced diagnostic lines join the synchronised ones
   assign req_lines = sync_lines[7:0] | {force_lines, 2'b00};

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire       go      = !dma_addr_inhibit_i;
   wire       h_cmd   = go & hit(io_addr_lines_i, `A_CMD);
   wire       h_data  = go & hit(io_addr_lines_i, `A_DATA);
   wire       h_vec   = go & hit(io_addr_lines_i, `A_VEC);
   wire       h_diag  = go & hit(io_addr_lines_i, `A_DIAG);
   wire       wr_edge = wr_prev & !io_write_strobe_n_i;
   wire       rd_on   = !io_read_strobe_n_i;
   wire       ack_fall = ack_prev & !ack_pulse_n_i;
   wire       ack_rise = !ack_prev & ack_pulse_n_i;
   wire       oper    = (init_state == `ST_OPER);
   wire       w_cmd   = wr_edge & h_cmd;
   wire       w_data  = wr_edge & h_data;
   wire       w_init1 = w_cmd & data_i[`I1_INIT];

   // ------------------------------------------------------------
   // arbitration
   // ------------------------------------------------------------
   wire [3:0] top_req = prio(pending_requests & ~level_mask);
   wire [3:0] top_isr = prio(in_service_levels);
   // a request preempts only a lower-priority level in service
   wire       grant   = top_req[3] &
                        (!top_isr[3] || top_req[2:0] < top_isr[2:0]);

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   reg [7:0] rd_data;
   reg       rd_hit;

   always @*
   begin
      rd_data = `BYTE_ZERO;
      rd_hit  = 1'b0;
      if (rd_on)
      begin
         if (h_data)
         begin
            rd_data = level_mask;
            rd_hit  = 1'b1;
         end
         else if (h_cmd)
         begin
            rd_data = op_word_three[`O3_RIS] ?
                      in_service_levels : pending_requests;
            rd_hit  = op_word_three[`O3_RR];
         end
         else if (h_vec)
         begin
            rd_data = vector_shadow;
            rd_hit  = diag_ctrl[`DG_VRD_EN];
         end
         else if (h_diag)
         begin
            rd_data = diag_ctrl;
            rd_hit  = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // next pending requests
   // ------------------------------------------------------------
   reg [7:0] next_irr;
   reg [7:0] req_set;

   always @*
   begin
      req_set  = level_trig ? req_lines : (req_lines & ~req_prev);
      next_irr = pending_requests;
      if (level_trig)
         next_irr = next_irr & req_lines;
      if (ack_fall && ack_state == `AK_IDLE && grant)
         next_irr[top_req[2:0]] = 1'b0;
      // a new edge in the clearing cycle is kept
      next_irr = next_irr | req_set;
      if (w_init1)
         next_irr = `BYTE_ZERO;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pending_requests  <= `BYTE_ZERO;
         in_service_levels <= `BYTE_ZERO;
         level_mask        <= `BYTE_ZERO;
         vector_base_word  <= `BYTE_ZERO;
         vector_shadow     <= `BYTE_ZERO;
         diag_ctrl         <= `BYTE_ZERO;
         force_lines       <= `FRC_RST;
         force_nmi         <= 1'b0;
         level_trig        <= 1'b0;
         need_w3           <= 1'b0;
         need_w4           <= 1'b0;
         auto_eoi          <= 1'b0;
         op_word_three     <= `O3_RST;
         init_state        <= `ST_OPER;
         ack_state         <= `AK_IDLE;
         ack_level         <= `LVL_SPUR;
         ack_vector        <= `BYTE_ZERO;
         req_prev          <= `BYTE_ZERO;
         wr_prev           <= 1'b1;
         ack_prev          <= 1'b1;
         data_o            <= `BYTE_ZERO;
         data_oe_o         <= 1'b0;
         buffer_dir_n_o    <= 1'b1;
         cpu_irq_out_o     <= 1'b0;
         nmi_force_o       <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (reset_i)
         begin
            pending_requests  <= `BYTE_ZERO;
            in_service_levels <= `BYTE_ZERO;
            level_mask        <= `BYTE_ZERO;
            vector_base_word  <= `BYTE_ZERO;
            vector_shadow     <= `BYTE_ZERO;
            diag_ctrl         <= `BYTE_ZERO;
            force_lines       <= `FRC_RST;
            force_nmi         <= 1'b0;
            level_trig        <= 1'b0;
            need_w3           <= 1'b0;
            need_w4           <= 1'b0;
            auto_eoi          <= 1'b0;
            op_word_three     <= `O3_RST;
            init_state        <= `ST_OPER;
            ack_state         <= `AK_IDLE;
            ack_level         <= `LVL_SPUR;
            ack_vector        <= `BYTE_ZERO;
            req_prev          <= `BYTE_ZERO;
            wr_prev           <= 1'b1;
            ack_prev          <= 1'b1;
            data_o            <= `BYTE_ZERO;
            data_oe_o         <= 1'b0;
            buffer_dir_n_o    <= 1'b1;
            cpu_irq_out_o     <= 1'b0;
            nmi_force_o       <= 1'b0;
         end
         else
         begin
            req_prev         <= req_lines;
            wr_prev          <= io_write_strobe_n_i;
            ack_prev         <= ack_pulse_n_i;
            pending_requests <= next_irr;

            // init sequence and operating writes
            if (w_init1)
            begin
               init_state        <= `ST_W2;
               level_trig        <= data_i[`I1_LTIM];
               need_w3           <= !data_i[`I1_SNGL];
               need_w4           <= data_i[`I1_IC4];
               auto_eoi          <= 1'b0;
               level_mask        <= `BYTE_ZERO;
               in_service_levels <= `BYTE_ZERO;
               op_word_three     <= `O3_RST;
            end
            else if (w_data)
            begin
               case (init_state)
                  `ST_W2:
                  begin
                     vector_base_word <= data_i;
                     vector_shadow    <= data_i;
                     init_state <= need_w3 ? `ST_W3 :
                                   (need_w4 ? `ST_W4 : `ST_OPER);
                  end
                  `ST_W3:
                     init_state <= need_w4 ? `ST_W4 : `ST_OPER;
                  `ST_W4:
                  begin
                     auto_eoi   <= data_i[`I4_AEOI];
                     init_state <= `ST_OPER;
                  end
                  default:
                     level_mask <= data_i;
               endcase
            end
            else if (w_cmd && oper)
            begin
               if (data_i[`O_SEL3])
               begin
                  // only a set read-select bit changes the choice
                  if (data_i[`O3_RR])
                     op_word_three <= data_i[`O3_RR:`O3_RIS];
               end
               else if (data_i[`O2_EOI])
               begin
                  if (data_i[`O2_SL])
                     in_service_levels[data_i[`O2_LV_HI:`O2_LV_LO]] <= 1'b0;
                  else if (top_isr[3])
                     in_service_levels[top_isr[2:0]] <= 1'b0;
               end
            end
            else if (wr_edge && h_diag)
               diag_ctrl <= data_i & `DIAG_MASK;
            else if (wr_edge && h_vec && diag_ctrl[`DG_WR_EN])
            begin
               force_lines <= data_i[`FRC_HI:`FRC_LO];
               force_nmi   <= data_i[`FRC_NMI] &
                              diag_ctrl[`DG_NMI_EN];
            end

            // acknowledge sequence: first pulse freezes, second drives
            case (ack_state)
               `AK_IDLE:
                  if (ack_fall)
                  begin
                     ack_state <= `AK_WAIT2;
                     ack_level <= grant ? top_req[2:0] : `LVL_SPUR;
                     if (grant && !w_init1)
                        in_service_levels[top_req[2:0]] <= 1'b1;
                  end
               `AK_WAIT2:
                  if (ack_fall)
                  begin
                     ack_state  <= `AK_DRIVE;
                     ack_vector <= (ack_level == `LVL_SHARED) ? `VEC_LVL1 :
                                   {vector_base_word[`VEC_HI:`VEC_LO], ack_level};
                     if (auto_eoi)
                        in_service_levels[ack_level] <= 1'b0;
                  end
               `AK_DRIVE:
                  if (ack_rise)
                     ack_state <= `AK_IDLE;
               default:
                  ack_state <= `AK_IDLE;
            endcase

            // bus drive follows the strobe it answers
            if (ack_state == `AK_DRIVE && !ack_pulse_n_i)
            begin
               data_o    <= ack_vector;
               data_oe_o <= 1'b1;
            end
            else
            begin
               data_o    <= rd_data;
               data_oe_o <= rd_hit;
            end
            buffer_dir_n_o <= !((ack_state == `AK_DRIVE && !ack_pulse_n_i)
                                || rd_hit);

            cpu_irq_out_o <= grant && oper;
            nmi_force_o   <= force_nmi;
         end
      end
   end
endmodule // interrupt_control_logic
`default_nettype wire

// ### inc/intctl_defs.vh
// constants for the interrupt control logic
`ifndef INTCTL_DEFS_VH
`define INTCTL_DEFS_VH
// ------------------------------------------------------------
// decoded i/o addresses
// ------------------------------------------------------------
`define ADDR_W      10
`define A_CMD       10'h020
`define A_DATA      10'h021
`define A_VEC       10'h063
`define A_DIAG      10'h069
// ------------------------------------------------------------
// diagnostic control bits (port 69h)
// ------------------------------------------------------------
`define DG_WR_EN    7
`define DG_VRD_EN   6
`define DG_NMI_EN   2
`define DIAG_MASK   8'hC4
// ------------------------------------------------------------
// force port bits (vector_shadow_and_force write)
// ------------------------------------------------------------
`define FRC_NMI     0
`define FRC_HI      7
`define FRC_LO      2
// ------------------------------------------------------------
// command word fields
// ------------------------------------------------------------
`define I1_INIT     4
`define I1_LTIM     3
`define I1_SNGL     1
`define I1_IC4      0
`define I4_AEOI     1
`define O_SEL3      3
`define O3_RR       1
`define O3_RIS      0
`define O2_SL       6
`define O2_EOI      5
`define O2_LV_HI    2
`define O2_LV_LO    0
`define O3_RST      2'h2
`define VEC_HI      7
`define VEC_LO      3
`define FRC_RST     6'h00
// ------------------------------------------------------------
// vectors, levels and reset values
// ------------------------------------------------------------
`define VEC_LVL1    8'h71
`define BYTE_ZERO   8'h00
`define LVL_SHARED  3'h1
`define LVL_SPUR    3'h7
`define SYNC_W      8
// ------------------------------------------------------------
// state codes
// ------------------------------------------------------------
`define ST_OPER     2'h0
`define ST_W2       2'h1
`define ST_W3       2'h2
`define ST_W4       2'h3
`define AK_IDLE     2'h0
`define AK_WAIT2    2'h1
`define AK_DRIVE    2'h2
`endif

// ### src/req_sync.v
// two-stage synchroniser for the interrupt request lines
`timescale 1ns/1ps
`default_nettype none
`include "intctl_defs.vh"
module req_sync
(
   input  wire                 clk_i,
   input  wire                 arst_n_i,
   input  wire                 clk_en_i,
   input  wire [`SYNC_W-1:0]   async_i,
   output reg  [`SYNC_W-1:0]   sync_o
);
   // ------------------------------------------------------------
   // stages
   // ------------------------------------------------------------
   // first stage is read by the second stage only
   reg [`SYNC_W-1:0] stage_one;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         stage_one <= {`SYNC_W{1'b0}};
         sync_o    <= {`SYNC_W{1'b0}};
      end
      else if (clk_en_i)
      begin
         stage_one <= async_i;
         sync_o    <= stage_one;
      end
   end
endmodule // req_sync
`default_nettype wire

// ### testbench/interrupt_control_logic_props.sv
// checker for the interrupt control logic ports
`timescale 1ns/1ps
`default_nettype none
`include "intctl_defs.vh"
module intctl_checker
(
   input wire logic               clk_i,
   input wire logic               arst_n_i,
   input wire logic               clk_en_i,
   input wire logic               reset_i,
   input wire logic [`ADDR_W-1:0] io_addr_lines_i,
   input wire logic               io_read_strobe_n_i,
   input wire logic               io_write_strobe_n_i,
   input wire logic               dma_addr_inhibit_i,
   input wire logic [7:0]         data_i,
   input wire logic [7:0]         data_o,
   input wire logic               data_oe_o,
   input wire logic               buffer_dir_n_o,
   input wire logic [7:2]         ext_request_lines_i,
   input wire logic               timer_irq_i,
   input wire logic               kbd_irq_i,
   input wire logic               mouse_irq_i,
   input wire logic               rtc_irq_i,
   input wire logic               ack_pulse_n_i,
   input wire logic               cpu_irq_out_o,
   input wire logic               nmi_force_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic ack_prev;
   logic ack_second;
   // ------------------------------------------------------------
   // acknowledge pulse parity: the vector only comes on the second
   // ------------------------------------------------------------
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ack_prev   <= 1'h1;
         ack_second <= 1'h0;
      end
      else if (clk_en_i)
      begin
         ack_prev <= ack_pulse_n_i;
         if (reset_i)
            ack_second <= 1'h0;
         else if (ack_prev && !ack_pulse_n_i)
            ack_second <= !ack_second;
      end
   end
   sequence s_rd_mask;
      !io_read_strobe_n_i && io_addr_lines_i == `A_DATA && !dma_addr_inhibit_i && ack_pulse_n_i;
   endsequence
   sequence s_second_pulse;
      ack_second && ack_prev && !ack_pulse_n_i ##1 !ack_pulse_n_i [*2];
   endsequence
   AST_DIR_OE: assert property (data_oe_o != buffer_dir_n_o)
      else $error("buffer direction disagrees with data drive");
   AST_IDLE_QUIET: assert property (io_read_strobe_n_i && ack_pulse_n_i |=> !data_oe_o)
      else $error("data driven without a read or acknowledge");
   AST_DMA_BLOCK: assert property (dma_addr_inhibit_i && ack_pulse_n_i |=> !data_oe_o)
      else $error("data driven during dma inhibit");
   AST_UNMAPPED: assert property (!io_read_strobe_n_i && ack_pulse_n_i
      && !(io_addr_lines_i inside {`A_CMD, `A_DATA, `A_VEC, `A_DIAG}) |=> !data_oe_o)
      else $error("unmapped address answered");
   AST_READ_DRIVE: assert property (s_rd_mask |=> data_oe_o && !buffer_dir_n_o)
      else $error("mask read not driven one cycle after strobe");
   AST_ACK_VEC: assert property (s_second_pulse |-> data_oe_o && !buffer_dir_n_o)
      else $error("vector not driven two cycles into second pulse");
   AST_SYNC_RESET: assert property (reset_i |=> !cpu_irq_out_o && !nmi_force_o && !data_oe_o)
      else $error("outputs not cleared by chip reset");
   AST_NMI_CAUSE: assert property (!$stable(nmi_force_o) |-> $past(reset_i)
      || !$past(io_write_strobe_n_i) || !$past(io_write_strobe_n_i, 2))
      else $error("nmi force changed without a write");
endmodule // intctl_checker
bind interrupt_control_logic intctl_checker intctl_checker_inst
(
   .clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .reset_i(reset_i),
   .io_addr_lines_i(io_addr_lines_i), .io_read_strobe_n_i(io_read_strobe_n_i),
   .io_write_strobe_n_i(io_write_strobe_n_i), .dma_addr_inhibit_i(dma_addr_inhibit_i),
   .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .buffer_dir_n_o(buffer_dir_n_o),
   .ext_request_lines_i(ext_request_lines_i), .timer_irq_i(timer_irq_i), .kbd_irq_i(kbd_irq_i),
   .mouse_irq_i(mouse_irq_i), .rtc_irq_i(rtc_irq_i), .ack_pulse_n_i(ack_pulse_n_i),
   .cpu_irq_out_o(cpu_irq_out_o), .nmi_force_o(nmi_force_o)
);
`default_nettype wire

// ### testbench/host_cpu_model.sv
// host cpu model: i/o channel cycles and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_oe_i,
   output logic [9:0]      addr_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic [7:0]      wdata_o,
   output logic            ack_n_o
);
   initial
   begin
      addr_o  = 10'h000;
      rd_n_o  = 1'h1;
      wr_n_o  = 1'h1;
      wdata_o = 8'h00;
      ack_n_o = 1'h1;
   end
   task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_n_o  <= 1'h0;
      repeat (2) @(posedge clk_i);
      wr_n_o  <= 1'h1;
      wdata_o <= ~d; // a released bus must not keep the old value
      repeat (2) @(posedge clk_i);
   endtask
   task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
      @(posedge clk_i);
      addr_o <= a;
      rd_n_o <= 1'h0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      d  = rd_data_i;
      oe = rd_oe_i;
      @(posedge clk_i);
      rd_n_o <= 1'h1;
      repeat (2) @(posedge clk_i);
   endtask
   // exactly two pulses; the vector is taken late in the second
   task automatic ack_seq(output logic [7:0] v, output logic oe);
      @(posedge clk_i);
      ack_n_o <= 1'h0;
      repeat (2) @(posedge clk_i);
      ack_n_o <= 1'h1;
      repeat (4) @(posedge clk_i);
      ack_n_o <= 1'h0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      v  = rd_data_i;
      oe = rd_oe_i;
      @(posedge clk_i);
      ack_n_o <= 1'h1;
      repeat (3) @(posedge clk_i);
   endtask
endmodule // host_cpu_model
`default_nettype wire

// ### testbench/testbench.sv
// testbench for the interrupt control logic
`timescale 1ns/1ps
`default_nettype none
`include "intctl_defs.vh"
module testbench;
   logic clk_i = 1'h0;
   logic arst_n_i = 1'h0;
   logic clk_en_i = 1'h1;
   logic reset_i = 1'h0;
   logic dma_addr_inhibit_i = 1'h0;
   logic [7:2] ext_request_lines_i = 6'h00;
   logic timer_irq_i = 1'h0;
   logic kbd_irq_i = 1'h0;
   logic mouse_irq_i = 1'h0;
   logic rtc_irq_i = 1'h0;
   logic [9:0] io_addr_lines_i;
   logic io_read_strobe_n_i, io_write_strobe_n_i, ack_pulse_n_i;
   logic [7:0] data_i, data_o, d;
   logic data_oe_o, buffer_dir_n_o, cpu_irq_out_o, nmi_force_o, oe;
   int error_cnt = 0;
   int n_checks = 0;
   int i;
   always #4 clk_i = ~clk_i;
   interrupt_control_logic interrupt_control_logic_inst
   (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .reset_i(reset_i),
      .io_addr_lines_i(io_addr_lines_i), .io_read_strobe_n_i(io_read_strobe_n_i),
      .io_write_strobe_n_i(io_write_strobe_n_i), .dma_addr_inhibit_i(dma_addr_inhibit_i),
      .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .buffer_dir_n_o(buffer_dir_n_o),
      .ext_request_lines_i(ext_request_lines_i), .timer_irq_i(timer_irq_i), .kbd_irq_i(kbd_irq_i),
      .mouse_irq_i(mouse_irq_i), .rtc_irq_i(rtc_irq_i), .ack_pulse_n_i(ack_pulse_n_i),
      .cpu_irq_out_o(cpu_irq_out_o), .nmi_force_o(nmi_force_o)
   );
   host_cpu_model host_cpu_model_inst
   (
      .clk_i(clk_i), .rd_data_i(data_o), .rd_oe_i(data_oe_o), .addr_o(io_addr_lines_i),
      .rd_n_o(io_read_strobe_n_i), .wr_n_o(io_write_strobe_n_i), .wdata_o(data_i), .ack_n_o(ack_pulse_n_i)
   );
   // ------------------------------------------------------------
   // shared checks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e, input logic oe_e);
      host_cpu_model_inst.io_rd(a, d, oe);
      chk({nm, "_oe"}, {7'h00, oe_e}, {7'h00, oe});
      if (oe_e)
         chk(nm, e, d);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      host_cpu_model_inst.io_wr(a, v);
   endtask
   task automatic ak(input string nm, input logic [7:0] e);
      host_cpu_model_inst.ack_seq(d, oe);
      chk({nm, "_oe"}, 8'h01, {7'h00, oe});
      chk(nm, e, d);
   endtask
   // fixed wait covers synchroniser plus pending and output stages
   task automatic irq(input logic e);
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      chk("cpu_irq", {7'h00, e}, {7'h00, cpu_irq_out_o});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt = error_cnt + 1;
      $display("watchdog expired");
      report_and_stop();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'h1;
      rd("mask_rst", `A_DATA, 8'h00, 1'h1);
      rd("shadow_closed", `A_VEC, 8'h00, 1'h0);
      wr(`A_DIAG, 8'h40);
      rd("shadow_rst", `A_VEC, 8'h00, 1'h1);
      $display("test reset_values done");
      wr(`A_CMD, 8'h13);
      wr(`A_DATA, 8'h08);
      wr(`A_DATA, 8'h01);
      rd("shadow", `A_VEC, 8'h08, 1'h1);
      rd("diag", `A_DIAG, 8'h40, 1'h1);
      rd("unmapped", 10'h221, 8'h00, 1'h0);
      wr(10'h221, 8'h55);
      rd("mask_alias", `A_DATA, 8'h00, 1'h1);
      $display("test init_decode done");
      wr(`A_CMD, 8'h0A);
      @(posedge clk_i);
      ext_request_lines_i <= 6'h12;
      irq(1'h1);
      rd("pending", `A_CMD, 8'h48, 1'h1);
      ak("vec_l3", 8'h0B);
      wr(`A_CMD, 8'h0B);
      rd("in_service", `A_CMD, 8'h08, 1'h1);
      wr(`A_CMD, 8'h20);
      ak("vec_l6", 8'h0E);
      wr(`A_CMD, 8'h63);
      rd("isr_spec", `A_CMD, 8'h40, 1'h1);
      wr(`A_CMD, 8'h66);
      rd("isr_clr", `A_CMD, 8'h00, 1'h1);
      @(posedge clk_i);
      ext_request_lines_i <= 6'h00;
      irq(1'h0);
      $display("test priority done");
      wr(`A_DATA, 8'h20);
      rd("mask", `A_DATA, 8'h20, 1'h1);
      @(posedge clk_i);
      ext_request_lines_i <= 6'h08;
      irq(1'h0);
      wr(`A_DATA, 8'h00);
      irq(1'h1);
      ak("vec_l5", 8'h0D);
      wr(`A_CMD, 8'h20);
      @(posedge clk_i);
      ext_request_lines_i <= 6'h00;
      $display("test mask done");
      for (i = 0; i < 3; i++)
      begin
         @(posedge clk_i);
         {kbd_irq_i, mouse_irq_i, rtc_irq_i} <= 3'h4 >> i;
         irq(1'h1);
         ak("vec_l1", 8'h71);
         wr(`A_CMD, 8'h20);
         @(posedge clk_i);
         {kbd_irq_i, mouse_irq_i, rtc_irq_i} <= 3'h0;
      end
      $display("test shared_level done");
      wr(`A_VEC, 8'h80);
      irq(1'h0);
      wr(`A_DIAG, 8'hC4);
      wr(`A_VEC, 8'h81);
      irq(1'h1);
      chk("nmi_on", 8'h01, {7'h00, nmi_force_o});
      ak("vec_l7", 8'h0F);
      wr(`A_VEC, 8'h00);
      wr(`A_CMD, 8'h20);
      wr(`A_DIAG, 8'h80);
      wr(`A_VEC, 8'h01);
      @(negedge clk_i);
      chk("nmi_blocked", 8'h00, {7'h00, nmi_force_o});
      wr(`A_VEC, 8'h00);
      $display("test force_port done");
      @(posedge clk_i);
      dma_addr_inhibit_i <= 1'h1;
      wr(`A_DATA, 8'hFF);
      rd("dma_read", `A_DATA, 8'h00, 1'h0);
      @(posedge clk_i);
      dma_addr_inhibit_i <= 1'h0;
      rd("dma_mask", `A_DATA, 8'h00, 1'h1);
      $display("test dma_inhibit done");
      wr(`A_DATA, 8'h5A);
      @(posedge clk_i);
      reset_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'h0;
      rd("mask_sync_rst", `A_DATA, 8'h00, 1'h1);
      rd("diag_sync_rst", `A_DIAG, 8'h00, 1'h1);
      ak("vec_spur", 8'h07);
      $display("test chip_reset done");
      wr(`A_CMD, 8'h19);
      wr(`A_DATA, 8'h20);
      wr(`A_DATA, 8'h00);
      wr(`A_DATA, 8'h02);
      @(posedge clk_i);
      clk_en_i <= 1'h0;
      timer_irq_i <= 1'h1;
      irq(1'h0);
      @(posedge clk_i);
      clk_en_i <= 1'h1;
      irq(1'h1);
      @(posedge clk_i);
      timer_irq_i <= 1'h0;
      irq(1'h0);
      @(posedge clk_i);
      timer_irq_i <= 1'h1;
      irq(1'h1);
      ak("vec_l0", 8'h20);
      wr(`A_CMD, 8'h0B);
      rd("isr_auto", `A_CMD, 8'h00, 1'h1);
      @(posedge clk_i);
      timer_irq_i <= 1'h0;
      $display("test level_mode done");
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
